// *** core/rtcb_map.vh ***
// register map, field layout, reset values and timing figures of the calendar clock
`ifndef RTCB_MAP_VH
`define RTCB_MAP_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define RTCB_A_TIME 8'h00
`define RTCB_A_DATE 8'h04
`define RTCB_A_CTRL 8'h08
`define RTCB_A_ALRM 8'h0c
`define RTCB_A_WUTR 8'h10
`define RTCB_A_CALB 8'h14
`define RTCB_A_STAT 8'h18
`define RTCB_A_MASK 8'h1c
`define RTCB_A_BKP 8'h40
`define RTCB_BKP_NUM 20
// -----------------------------------------------------------------
// control bits, status bits
// -----------------------------------------------------------------
`define RTCB_C_FMT12 0
`define RTCB_C_ALREN 1
`define RTCB_C_WUTEN 2
`define RTCB_C_CALEN 3
`define RTCB_S_ALARM 0
`define RTCB_S_WAKE 1
`define RTCB_S_TAMP 2
`define RTCB_CALP_BIT 15
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RTCB_R_HOUR 6'h00
`define RTCB_R_WDAY 3'h1
`define RTCB_R_DATE 6'h01
`define RTCB_R_MON 5'h01
`define RTCB_R_YEAR 8'h00
`define RTCB_R_WUTR 16'hffff
// -----------------------------------------------------------------
// timing: prescaler split, compensation window, wakeup range
// -----------------------------------------------------------------
`define RTCB_ADIV_W 7
`define RTCB_SDIV_W 8
`define RTCB_CALWIN_W 20
`define RTCB_CALP_N 20'h00200
`define RTCB_WUT_MIN_US 120
`define RTCB_WUT_MAX_H 36
`endif

// *** core/rtcb_bkp_mem.v ***
// backup word store with tamper wipe and registered read port
`timescale 1ns/1ps
`default_nettype none
module rtcb_bkp_mem #(
    parameter NUM = 20,
    parameter AW = 5
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // wipe and write
    input wire wipe,
    input wire wr,
    input wire [AW-1:0] widx,
    input wire [31:0] wdata,
    // read
    input wire rd,
    input wire hit,
    input wire [AW-1:0] ridx,
    input wire [31:0] alt,
    output reg [31:0] rdata
);
reg [31:0] mem [0:NUM-1];
integer i;
always @(posedge clk) begin
    if (rst || wipe) begin
        for (i = 0; i < NUM; i = i + 1) begin
            mem[i] <= 32'h0000_0000;
        end
    end else if (wr) begin
        mem[widx] <= wdata;
    end
end
// non-backup reads ride the same register so read data always come from a flop
always @(posedge clk) begin
    if (rst) begin
        rdata <= 32'h0000_0000;
    end else if (rd) begin
        rdata <= hit ? mem[ridx] : alt;
    end else begin
        rdata <= 32'h0000_0000;
    end
end
endmodule // rtcb_bkp_mem
`default_nettype wire

// *** core/rtcb_wakeup.v ***
// periodic wakeup down-counter
`timescale 1ns/1ps
`default_nettype none
module rtcb_wakeup (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire en,
    input wire [2:0] sel,
    input wire [15:0] reload,
    // time bases
    input wire lse_tick,
    input wire spre_tick,
    // event
    output reg wake
);
reg [3:0] div;
reg [16:0] cnt;
reg tick;
wire [16:0] load = {sel[2] & sel[1], reload};
always @* begin
    case (sel)
        3'h0: tick = lse_tick & (div == 4'hf);
        3'h1: tick = lse_tick & (div[2:0] == 3'h7);
        3'h2: tick = lse_tick & (div[1:0] == 2'h3);
        3'h3: tick = lse_tick & div[0];
        default: tick = spre_tick;
    endcase
end
always @(posedge clk) begin
    if (rst) begin
        div <= 4'h0;
        cnt <= 17'h00000;
        wake <= 1'b0;
    end else begin
        if (lse_tick) begin
            div <= div + 4'h1;
        end
        wake <= 1'b0;
        if (!en) begin
            cnt <= load;
        end else if (tick) begin
            if (cnt == 17'h00000) begin
                cnt <= load;
                wake <= 1'b1;
            end else begin
                cnt <= cnt - 17'h00001;
            end
        end
    end
end
endmodule // rtcb_wakeup
`default_nettype wire

// *** core/rtcb_top.v ***
// BCD calendar clock with alarm, wakeup, calibration, compensation and backup words
// -----------------------------------------------------------------
// -----------------------------------------------------------------
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_map.vh"
module rtcb_top (
    // clock and backup-domain reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output wire [31:0] rdata,
    // pins and power state
    input wire lse_clk,
    input wire tamper,
    input wire standby,
    // outputs
    output reg cal_out,
    output reg irq,
    output reg wake_out
);
// -----------------------------------------------------------------
// helpers
// -----------------------------------------------------------------
function [7:0] bcd_inc;
    input [7:0] v;
    begin
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    end
endfunction
function [5:0] month_len;
    input [4:0] m;
    input [7:0] y;
    reg leap;
    begin
        if (y[4]) begin
            leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        case (m)
            5'h02: month_len = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_len = 6'h30;
            default: month_len = 6'h31;
        endcase
    end
endfunction
// -----------------------------------------------------------------
// state
// -----------------------------------------------------------------
reg [6:0] sec, min;
reg [5:0] hour;
reg pm;
reg [2:0] wday;
reg [5:0] date;
reg [4:0] month;
reg [7:0] year;
reg [22:0] alarm;
reg [8:0] ctrl;
reg [15:0] wut_reload;
reg [15:0] calib;
reg [2:0] stat, mask;
reg lse_s1, lse_s2, lse_s3;
reg tmp_s1, tmp_s2, tmp_s3;
reg raw_d;
reg [`RTCB_CALWIN_W-1:0] win;
reg [`RTCB_ADIV_W-1:0] adiv;
reg [`RTCB_SDIV_W-1:0] sdiv;
reg sec_tick, tick_d;
reg [6:0] next_sec, next_min;
reg [5:0] next_hour;
reg next_pm;
reg [2:0] next_wday;
reg [5:0] next_date;
reg [4:0] next_month;
reg [7:0] next_year;
reg [2:0] next_stat;
reg day_carry;
reg [31:0] alt;
wire wake_ev;
// -----------------------------------------------------------------
// bus decode
// -----------------------------------------------------------------
// bus is fenced off in standby so nothing disturbs the kept state
wire bus_wr = wr & ~standby;
wire bus_rd = rd & ~standby;
wire [7:0] boff = addr - `RTCB_A_BKP;
wire bkp_hit = (addr >= `RTCB_A_BKP) && (boff < 8'h50);
wire [4:0] bidx = boff[6:2];
wire w_time = bus_wr && (addr == `RTCB_A_TIME);
wire w_date = bus_wr && (addr == `RTCB_A_DATE);
wire r_stat = bus_rd && (addr == `RTCB_A_STAT);
wire fmt12 = ctrl[`RTCB_C_FMT12];
// -----------------------------------------------------------------
// pin synchronisers and edge detect
// -----------------------------------------------------------------
always @(posedge clk) begin
    if (rst) begin
        lse_s1 <= 1'b0;
        lse_s2 <= 1'b0;
        lse_s3 <= 1'b0;
        tmp_s1 <= 1'b0;
        tmp_s2 <= 1'b0;
        tmp_s3 <= 1'b0;
    end else begin
        lse_s1 <= lse_clk;
        lse_s2 <= lse_s1;
        lse_s3 <= lse_s2;
        tmp_s1 <= tamper;
        tmp_s2 <= tmp_s1;
        tmp_s3 <= tmp_s2;
    end
end
wire raw_tick = lse_s2 & ~lse_s3;
wire tamp_ev = tmp_s2 & ~tmp_s3;
// -----------------------------------------------------------------
// drift compensation and prescaler
// -----------------------------------------------------------------
// skipped ticks sit at the start of each 2^20-tick window; the window
// is about 32 s, so the correction is only exact when averaged over it
wire skip = ({11'h000, calib[8:0]} > win);
wire ins = calib[`RTCB_CALP_BIT] && (win < `RTCB_CALP_N);
wire comp_tick = (raw_tick & ~skip) | (raw_d & ins);
wire apre_tick = comp_tick && (adiv == {`RTCB_ADIV_W{1'b1}});
wire spre_tick = apre_tick && (sdiv == {`RTCB_SDIV_W{1'b1}});
always @(posedge clk) begin
    if (rst) begin
        raw_d <= 1'b0;
        win <= {`RTCB_CALWIN_W{1'b0}};
        adiv <= {`RTCB_ADIV_W{1'b0}};
        sdiv <= {`RTCB_SDIV_W{1'b0}};
        sec_tick <= 1'b0;
        tick_d <= 1'b0;
        cal_out <= 1'b0;
    end else begin
        raw_d <= raw_tick;
        if (raw_tick) begin
            win <= win + {{(`RTCB_CALWIN_W-1){1'b0}}, 1'b1};
        end
        if (comp_tick) begin
            adiv <= adiv + {{(`RTCB_ADIV_W-1){1'b0}}, 1'b1};
        end
        if (w_time) begin
            sdiv <= {`RTCB_SDIV_W{1'b0}};
        end else if (apre_tick) begin
            sdiv <= sdiv + {{(`RTCB_SDIV_W-1){1'b0}}, 1'b1};
        end
        sec_tick <= spre_tick & ~w_time;
        tick_d <= sec_tick;
        // bit 5 of the 128 divider toggles every 32 ticks: 512 Hz at 32768 Hz
        cal_out <= ctrl[`RTCB_C_CALEN] & adiv[5];
    end
end
// -----------------------------------------------------------------
// calendar next state
// -----------------------------------------------------------------
wire [7:0] sec_inc = bcd_inc({1'b0, sec});
wire [7:0] min_inc = bcd_inc({1'b0, min});
wire [7:0] hour_inc = bcd_inc({2'b00, hour});
wire [7:0] date_inc = bcd_inc({2'b00, date});
wire [7:0] mon_inc = bcd_inc({3'b000, month});
wire [7:0] year_inc = bcd_inc(year);
always @* begin
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_pm = pm;
    next_wday = wday;
    next_date = date;
    next_month = month;
    next_year = year;
    day_carry = 1'b0;
    if (sec_tick) begin
        next_sec = sec_inc[6:0];
        if (sec == 7'h59) begin
            next_sec = 7'h00;
            next_min = min_inc[6:0];
            if (min == 7'h59) begin
                next_min = 7'h00;
                next_hour = hour_inc[5:0];
                if (fmt12) begin
                    if (hour == 6'h12) begin
                        next_hour = 6'h01;
                    end else if (hour == 6'h11) begin
                        next_pm = ~pm;
                        day_carry = pm;
                    end
                end else if (hour == 6'h23) begin
                    next_hour = 6'h00;
                    day_carry = 1'b1;
                end
            end
        end
    end
    if (day_carry) begin
        next_wday = (wday == 3'h7) ? 3'h1 : wday + 3'h1;
        next_date = date_inc[5:0];
        if (date == month_len(month, year)) begin
            next_date = 6'h01;
            next_month = mon_inc[4:0];
            if (month == 5'h12) begin
                next_month = 5'h01;
                next_year = year_inc;
            end
        end
    end
end
// -----------------------------------------------------------------
// calendar and configuration registers
// -----------------------------------------------------------------
// only the backup-domain reset clears this; standby leaves it counting
always @(posedge clk) begin
    if (rst) begin
        sec <= 7'h00;
        min <= 7'h00;
        hour <= `RTCB_R_HOUR;
        pm <= 1'b0;
        wday <= `RTCB_R_WDAY;
        date <= `RTCB_R_DATE;
        month <= `RTCB_R_MON;
        year <= `RTCB_R_YEAR;
        ctrl <= 9'h000;
        alarm <= 23'h000000;
        wut_reload <= `RTCB_R_WUTR;
        calib <= 16'h0000;
        mask <= 3'h0;
    end else begin
        if (w_time) begin
            sec <= wdata[6:0];
            min <= wdata[14:8];
            hour <= wdata[21:16];
            pm <= wdata[22];
        end else begin
            sec <= next_sec;
            min <= next_min;
            hour <= next_hour;
            pm <= next_pm;
        end
        if (w_date) begin
            date <= wdata[5:0];
            month <= wdata[12:8];
            wday <= wdata[15:13];
            year <= wdata[23:16];
        end else begin
            date <= next_date;
            month <= next_month;
            wday <= next_wday;
            year <= next_year;
        end
        if (bus_wr && (addr == `RTCB_A_CTRL)) begin
            ctrl <= wdata[8:0];
        end
        if (bus_wr && (addr == `RTCB_A_ALRM)) begin
            alarm <= wdata[22:0];
        end
        if (bus_wr && (addr == `RTCB_A_WUTR)) begin
            wut_reload <= wdata[15:0];
        end
        if (bus_wr && (addr == `RTCB_A_CALB)) begin
            calib <= wdata[15:0];
        end
        if (bus_wr && (addr == `RTCB_A_MASK)) begin
            mask <= wdata[2:0];
        end
    end
end
// -----------------------------------------------------------------
// events, status and interrupt
// -----------------------------------------------------------------
wire [22:0] now = {pm, hour, 1'b0, min, 1'b0, sec};
wire alarm_ev = ctrl[`RTCB_C_ALREN] && tick_d && (now == alarm);
always @* begin
    next_stat = stat;
    if (r_stat) begin
        next_stat = 3'h0;
    end
    // a new event wins over the read that clears
    next_stat = next_stat | {tamp_ev, wake_ev, alarm_ev};
end
always @(posedge clk) begin
    if (rst) begin
        stat <= 3'h0;
        irq <= 1'b0;
        wake_out <= 1'b0;
    end else begin
        stat <= next_stat;
        irq <= |(stat & mask);
        // wake request ignores the mask so stop and standby exit always work
        wake_out <= stat[`RTCB_S_ALARM] | stat[`RTCB_S_WAKE];
    end
end
// -----------------------------------------------------------------
// wakeup timer
// -----------------------------------------------------------------
rtcb_wakeup u_wake (
    .clk(clk),
    .rst(rst),
    .en(ctrl[`RTCB_C_WUTEN]),
    .sel(ctrl[6:4]),
    .reload(wut_reload),
    .lse_tick(comp_tick),
    .spre_tick(spre_tick),
    .wake(wake_ev)
);
// -----------------------------------------------------------------
// read mux and backup words
// -----------------------------------------------------------------
always @* begin
    case (addr)
        `RTCB_A_TIME: alt = {9'h000, now};
        `RTCB_A_DATE: alt = {8'h00, year, wday, month, 2'b00, date};
        `RTCB_A_CTRL: alt = {23'h000000, ctrl};
        `RTCB_A_ALRM: alt = {9'h000, alarm};
        `RTCB_A_WUTR: alt = {16'h0000, wut_reload};
        `RTCB_A_CALB: alt = {16'h0000, calib};
        `RTCB_A_STAT: alt = {29'h00000000, stat};
        `RTCB_A_MASK: alt = {29'h00000000, mask};
        default: alt = 32'h0000_0000;
    endcase
end
rtcb_bkp_mem #(
    .NUM(`RTCB_BKP_NUM),
    .AW(5)
) u_bkp (
    .clk(clk),
    .rst(rst),
    .wipe(tamp_ev),
    .wr(bus_wr & bkp_hit),
    .widx(bidx),
    .wdata(wdata),
    .rd(bus_rd),
    .hit(bkp_hit),
    .ridx(bidx),
    .alt(alt),
    .rdata(rdata)
);
endmodule // rtcb_top
`default_nettype wire

// *** verif/rtcb_assertions.sv ***
// port-level checks of the calendar clock block
`timescale 1ns/1ps
`default_nettype none
module rtcb_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // pins and outputs
    input wire logic lse_clk,
    input wire logic tamper,
    input wire logic standby,
    input wire logic cal_out,
    input wire logic irq,
    input wire logic wake_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // read port
    // ----------------------------------------
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    unmapped_zero_a: assert property ($past(rd && (addr > 8'h8f
        || (addr > 8'h1f && addr < 8'h40))) |-> rdata == 32'h0)
        else $error("unmapped read gave nonzero data");
    stby_fence_a: assert property ($past(rd && standby) |-> rdata == 32'h0)
        else $error("read in standby gave data");
    time_bcd_a: assert property ($past(rd && !standby && addr == 8'h00)
        |-> rdata[3:0] < 4'ha && rdata[6:4] < 3'h6 && rdata[11:8] < 4'ha && rdata[14:12] < 3'h6
        && rdata[19:16] < 4'ha && rdata[21:16] < 6'h24)
        else $error("time field not decimal");
    date_bcd_a: assert property ($past(rd && !standby && addr == 8'h04)
        |-> rdata[5:0] != 6'h0 && rdata[5:0] < 6'h32 && rdata[12:8] != 5'h0
        && rdata[12:8] < 5'h13 && rdata[15:13] != 3'h0)
        else $error("date field out of range");
    // ----------------------------------------
    // calibration output and events
    // ----------------------------------------
    // calibration only moves on slow ticks or register writes
    cal_hold_a: assert property ((!wr && $stable(lse_clk)) [*8] |=> $stable(cal_out))
        else $error("calibration output moved without a slow tick");
    wake_fall_a: assert property ($fell(wake_out)
        |-> $past(rd && !standby && addr == 8'h18, 2))
        else $error("wake request dropped without a status read");
    irq_fall_a: assert property ($fell(irq) |-> $past(!standby
        && ((rd && addr == 8'h18) || (wr && addr == 8'h1c)), 2))
        else $error("interrupt dropped without read or mask write");
endmodule // rtcb_checker
bind rtcb_top rtcb_checker u_rtcb_checker (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lse_clk(lse_clk), .tamper(tamper), .standby(standby),
    .cal_out(cal_out), .irq(irq), .wake_out(wake_out));
`default_nettype wire

// *** verif/bcd_calendar_rtc_backup_test.sv ***
// self-checking bench for the calendar clock block
`timescale 1ns/1ps
`default_nettype none
module bcd_calendar_rtc_backup_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic lse_clk = 1'b0;
    logic tamper = 1'b0;
    logic standby = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [2:0] lse_div = 3'h0;
    logic lse_hold = 1'b0;
    logic [31:0] rd_val;
    logic [31:0] bk [0:19];
    wire [31:0] rdata;
    wire cal_out;
    wire irq;
    wire wake_out;
    integer fails = 0;
    integer checked = 0;
    integer seed = 57;
    integer lse_cnt = 0;
    integer i, n, r0, p0;
    rtcb_top u_rtcb_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .lse_clk(lse_clk), .tamper(tamper), .standby(standby),
        .cal_out(cal_out), .irq(irq), .wake_out(wake_out));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // slow clock: a rise every 8 clk, phase restarted by reset so runs repeat exactly
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            lse_div <= 3'h0;
            lse_clk <= 1'b0;
            lse_cnt <= 0;
        end else if (!lse_hold) begin
            lse_div <= lse_div + 3'h1;
            lse_clk <= (lse_div >= 3'h3) && (lse_div != 3'h7);
            if (lse_div == 3'h3) lse_cnt <= lse_cnt + 1;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [7:0] reg_addr(input integer k);
        reg_addr = (k < 8) ? 8'(k * 4) : 8'h40;
    endfunction
    function logic [31:0] reset_val(input logic [7:0] a);
        case (a)
            8'h04: reset_val = 32'h0000_2101;
            8'h10: reset_val = 32'h0000_ffff;
            default: reset_val = 32'h0;
        endcase
    endfunction
    task check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checked = checked + 1;
        if (seen !== want) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rd_val = rdata;
    endtask
    // bounded wait for cal_out (0), wake_out (1) or irq (2) to reach a level
    task wait_lvl(input integer which, input logic lvl);
        integer k;
        k = 0;
        while (k < 30000 && (which == 0 ? cal_out : which == 1 ? wake_out : irq) !== lvl) begin
            @(negedge clk);
            k = k + 1;
        end
        if (k >= 30000) begin
            check("wait timeout", 32'h1, 32'h0);
            complete_run;
        end
    endtask
    // first calibration rise and its period, both counted in slow-clock rises
    task cal_run(input logic [31:0] calb, output integer first, output integer period);
        do_reset;
        wr_reg(8'h14, calb);
        wr_reg(8'h08, 32'h0000_0008);
        wait_lvl(0, 1'b1);
        first = lse_cnt;
        wait_lvl(0, 1'b0);
        wait_lvl(0, 1'b1);
        period = lse_cnt - first;
        // stall the slow clock so the calibration output has to sit still
        @(posedge clk);
        lse_hold <= 1'b1;
        repeat (24) @(posedge clk);
        lse_hold <= 1'b0;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        do_reset;
        for (i = 0; i < 9; i = i + 1) begin
            rd_reg(reg_addr(i));
            check("reset value", rd_val, reset_val(reg_addr(i)));
        end
        n = 0;
        repeat (600) begin
            @(negedge clk);
            if (cal_out !== 1'b0) n = n + 1;
        end
        check("cal idle", n, 0);
        for (i = 0; i < 20; i = i + 1) begin
            bk[i] = $random(seed);
            wr_reg(8'h40 + 8'(i * 4), bk[i]);
        end
        wr_reg(8'h20, $random(seed));
        wr_reg(8'h90, $random(seed));
        wr_reg(8'h08, 32'h0000_0001);
        wr_reg(8'h00, 32'h0052_3456);
        wr_reg(8'h04, 32'h0024_8229);
        wr_reg(8'h0c, 32'h0011_0203);
        for (i = 0; i < 20; i = i + 1) begin
            rd_reg(8'h40 + 8'(i * 4));
            check("backup word", rd_val, bk[i]);
        end
        rd_reg(8'h20);
        check("unmapped low", rd_val, 32'h0);
        rd_reg(8'h90);
        check("unmapped high", rd_val, 32'h0);
        rd_reg(8'h08);
        check("twelve hour mode", rd_val, 32'h0000_0001);
        rd_reg(8'h00);
        check("time pm", rd_val, 32'h0052_3456);
        rd_reg(8'h04);
        check("leap date", rd_val, 32'h0024_8229);
        rd_reg(8'h0c);
        check("alarm time", rd_val, 32'h0011_0203);
        // standby fences the bus but the words hold
        @(posedge clk);
        standby <= 1'b1;
        wr_reg(8'h40, ~bk[0]);
        rd_reg(8'h40);
        check("standby read", rd_val, 32'h0);
        @(posedge clk);
        standby <= 1'b0;
        rd_reg(8'h40);
        check("standby hold", rd_val, bk[0]);
        // tamper while masked, then unmask, mask and clear
        @(posedge clk);
        tamper <= 1'b1;
        repeat (8) @(posedge clk);
        tamper <= 1'b0;
        @(negedge clk);
        check("masked irq", irq, 1'b0);
        for (i = 0; i < 20; i = i + 1) begin
            rd_reg(8'h40 + 8'(i * 4));
            check("wiped word", rd_val, 32'h0);
        end
        wr_reg(8'h1c, 32'h0000_0004);
        wait_lvl(2, 1'b1);
        wr_reg(8'h1c, 32'h0);
        repeat (3) @(negedge clk);
        check("irq masked off", irq, 1'b0);
        rd_reg(8'h18);
        check("tamper status", rd_val, 32'h0000_0004);
        // wakeup at every fast tick select, standby held through one period
        wr_reg(8'h1c, 32'h0000_0002);
        for (i = 0; i < 4; i = i + 1) begin
            n = 2 + ($random(seed) & 7);
            wr_reg(8'h10, n);
            wr_reg(8'h08, 32'h0000_0004 | (i << 4));
            wait_lvl(1, 1'b1);
            r0 = lse_cnt;
            check("wake irq", irq, 1'b1);
            rd_reg(8'h18);
            check("wake status", rd_val, 32'h0000_0002);
            wait_lvl(1, 1'b0);
            @(posedge clk);
            standby <= (i == 2);
            wait_lvl(1, 1'b1);
            check("wake period", lse_cnt - r0, (n + 1) * (16 >> i));
            @(posedge clk);
            standby <= 1'b0;
            wr_reg(8'h08, 32'h0);
            rd_reg(8'h18);
        end
        // calibration output with plain, skipping and inserting compensation
        cal_run(32'h0, r0, p0);
        check("cal period", p0, 64);
        cal_run(32'h0000_0014, n, p0);
        check("skip delay", n - r0, 20);
        cal_run(32'h0000_8000, n, p0);
        check("insert period", p0, 32);
        complete_run;
    end
endmodule // bcd_calendar_rtc_backup_test
`default_nettype wire
